// ### verilog/drive_command_word_decoder.sv
// Decoder from the fieldbus command word to internal drive commands
`timescale 1ns/100ps
`default_nettype none

module drive_command_word_decoder (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 cmdWrite,
  input  wire logic [31:0]          cmdWord,
  input  wire logic                 refNegative,
  input  wire logic                 faultActive,
  input  wire logic                 locFromBus,
  input  wire logic                 runEnFromBus,
  input  wire logic                 accelSetFromBus,
  input  wire logic                 torqueSetFromBus,
  input  wire logic [1:0]           paramStopMode,
  output logic      [15:0]          driveCmdWord,
  output logic                      stopCmd,
  output logic                      startCmd,
  output logic      [1:0]           stopMode,
  output logic                      dirReverse,
  output logic                      faultResetPulse,
  output logic                      secondExternalLocation,
  output logic                      runEnable,
  output logic                      accelSetSelect,
  output logic                      rampOutZero,
  output logic                      rampHold,
  output logic                      rampInZero,
  output logic                      localLock,
  output logic                      torqueBoundSetSelect,
  output logic                      busControlTakeover,
  output logic                      busReferenceTakeover,
  output logic      [3:0]           userBits
);

  // Incoming word view: the write if one is made, else the word already held
  logic [31:0] heldWord;
  logic [31:0] nextWord;
  // Stored fields of the command word
  logic [15:0] lowWord_q;
  logic [15:0] lowWord_d;
  logic        ctlTake_q;
  logic        ctlTake_d;
  logic        refTake_q;
  logic        refTake_d;
  logic [3:0]  user_q;
  logic [3:0]  user_d;
  // Derived commands
  logic        faultRst_q;
  logic        faultRst_d;
  logic        dir_q;
  logic        dir_d;
  logic [1:0]  stop_q;
  logic [1:0]  stop_d;
  // Selections that may follow the bus
  logic        secondLoc_q;
  logic        secondLoc_d;
  logic        runEn_q;
  logic        runEn_d;
  logic        accel_q;
  logic        accel_d;
  logic        torque_q;
  logic        torque_d;

  // Lowest set request bit wins when several stop modes are asked at once
  function automatic logic [1:0] pickStopMode(
    input logic [31:0] w,
    input logic [1:0]  dflt
  );
    logic [1:0] mode;
    mode = dflt;
    if (w[cmd_word_pkg::BIT_STOP_FREE]) begin
      mode = 2'(cmd_word_pkg::STOP_BY_FREEWHEEL);
    end
    if (w[cmd_word_pkg::BIT_STOP_URGENT]) begin
      mode = 2'(cmd_word_pkg::STOP_BY_URGENT_SLOPE);
    end
    if (w[cmd_word_pkg::BIT_STOP_NORMAL]) begin
      mode = 2'(cmd_word_pkg::STOP_BY_NORMAL_SLOPE);
    end
    return mode;
  endfunction

  // A selection follows the bus only while configured to, else it holds
  function automatic logic followBus(
    input logic sourced,
    input logic fromWord,
    input logic held
  );
    logic result;
    result = held;
    if (sourced) begin
      result = fromWord;
    end
    return result;
  endfunction

  // Rising edge of one bit between the held and the incoming word
  function automatic logic wordBitRose(
    input logic [31:0] newWord,
    input logic [31:0] oldWord,
    input int          pos
  );
    logic rose;
    rose = newWord[pos] & ~oldWord[pos];
    return rose;
  endfunction

  // Reserved positions are cleared on entry so they can never reach a command
  always_comb begin
    heldWord = {6'h00, user_q, 4'h0, refTake_q, ctlTake_q, lowWord_q};
    nextWord = heldWord;
    if (cmdWrite) begin
      nextWord = cmdWord & cmd_word_pkg::CMD_USED_MASK;
    end
  end

  // Lower half passed on as is
  always_comb begin
    lowWord_d = nextWord[cmd_word_pkg::DRIVE_W-1:0];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lowWord_q <= 16'h0000;
    end else begin
      lowWord_q <= lowWord_d;
    end
  end

  // Control takeover request
  always_comb begin
    ctlTake_d = nextWord[cmd_word_pkg::BIT_CTL_TAKE];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctlTake_q <= 1'h0;
    end else begin
      ctlTake_q <= ctlTake_d;
    end
  end

  // Reference takeover request
  always_comb begin
    refTake_d = nextWord[cmd_word_pkg::BIT_REF_TAKE];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      refTake_q <= 1'h0;
    end else begin
      refTake_q <= refTake_d;
    end
  end

  // User bits carry no meaning here
  always_comb begin
    user_d = nextWord[cmd_word_pkg::USER_LO +: cmd_word_pkg::USER_W];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      user_q <= 4'h0;
    end else begin
      user_q <= user_d;
    end
  end

  // Edge is taken against the stored word so a held bit resets only once
  always_comb begin
    faultRst_d = wordBitRose(nextWord, heldWord, cmd_word_pkg::BIT_FAULT_RESET) & faultActive;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      faultRst_q <= 1'h0;
    end else begin
      faultRst_q <= faultRst_d;
    end
  end

  // Direction from reverse bit and reference sign
  always_comb begin
    dir_d = nextWord[cmd_word_pkg::BIT_REVERSE] ^ refNegative;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dir_q <= 1'h0;
    end else begin
      dir_q <= dir_d;
    end
  end

  // Stop method
  always_comb begin
    stop_d = pickStopMode(nextWord, paramStopMode);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stop_q <= 2'h0;
    end else begin
      stop_q <= stop_d;
    end
  end

  // Selections keep their last value while the bus is not the source
  // Location choice
  always_comb begin
    secondLoc_d = followBus(locFromBus, nextWord[cmd_word_pkg::BIT_LOC_SEL], secondLoc_q);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      secondLoc_q <= 1'h0;
    end else begin
      secondLoc_q <= secondLoc_d;
    end
  end

  // Run enable, active when the disable bit is clear
  always_comb begin
    runEn_d = followBus(runEnFromBus, ~nextWord[cmd_word_pkg::BIT_RUN_DISABLE], runEn_q);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      runEn_q <= 1'h0;
    end else begin
      runEn_q <= runEn_d;
    end
  end

  // Ramp set choice
  always_comb begin
    accel_d = followBus(accelSetFromBus, nextWord[cmd_word_pkg::BIT_ACCEL_SET], accel_q);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      accel_q <= 1'h0;
    end else begin
      accel_q <= accel_d;
    end
  end

  // Torque limit set choice
  always_comb begin
    torque_d = followBus(torqueSetFromBus, nextWord[cmd_word_pkg::BIT_TORQUE_SET], torque_q);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      torque_q <= 1'h0;
    end else begin
      torque_q <= torque_d;
    end
  end

  // Every output is a flip-flop or a bit of one
  assign driveCmdWord           = lowWord_q;
  assign stopCmd                = lowWord_q[cmd_word_pkg::BIT_STOP];
  assign startCmd               = lowWord_q[cmd_word_pkg::BIT_START];
  assign rampOutZero            = lowWord_q[cmd_word_pkg::BIT_RAMP_OUT_Z];
  assign rampHold               = lowWord_q[cmd_word_pkg::BIT_RAMP_HOLD];
  assign rampInZero             = lowWord_q[cmd_word_pkg::BIT_RAMP_IN_Z];
  assign localLock              = lowWord_q[cmd_word_pkg::BIT_LOCAL_LOCK];
  assign busControlTakeover     = ctlTake_q;
  assign busReferenceTakeover   = refTake_q;
  assign userBits               = user_q;
  assign stopMode               = stop_q;
  assign dirReverse             = dir_q;
  assign faultResetPulse        = faultRst_q;
  assign secondExternalLocation = secondLoc_q;
  assign runEnable              = runEn_q;
  assign accelSetSelect         = accel_q;
  assign torqueBoundSetSelect   = torque_q;

endmodule // drive_command_word_decoder

`default_nettype wire

// ### verilog/cmd_word_pkg.sv
// Constants for the plain-profile command word decoder
`default_nettype none
package cmd_word_pkg;
  localparam int WORD_W          = 32;
  localparam int BIT_STOP        = 0;
  localparam int BIT_START       = 1;
  localparam int BIT_REVERSE     = 2;
  localparam int BIT_FAULT_RESET = 4;
  localparam int BIT_LOC_SEL     = 5;
  localparam int BIT_RUN_DISABLE = 6;
  localparam int BIT_STOP_NORMAL = 7;
  localparam int BIT_STOP_URGENT = 8;
  localparam int BIT_STOP_FREE   = 9;
  localparam int BIT_ACCEL_SET   = 10;
  localparam int BIT_RAMP_OUT_Z  = 11;
  localparam int BIT_RAMP_HOLD   = 12;
  localparam int BIT_RAMP_IN_Z   = 13;
  localparam int BIT_LOCAL_LOCK  = 14;
  localparam int BIT_TORQUE_SET  = 15;
  localparam int BIT_CTL_TAKE    = 16;
  localparam int BIT_REF_TAKE    = 17;
  localparam int USER_LO         = 22;
  localparam int USER_W          = 4;
  localparam int DRIVE_W         = 16;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  // Used-bit mask: everything else is reserved and dropped
  localparam logic [31:0] CMD_USED_MASK = 32'h03C3_FFF7;

  typedef enum logic [1:0] {
    STOP_BY_PARAM         = 2'b00,
    STOP_BY_NORMAL_SLOPE  = 2'b01,
    STOP_BY_URGENT_SLOPE  = 2'b10,
    STOP_BY_FREEWHEEL     = 2'b11
  } stop_mode_t;
endpackage : cmd_word_pkg
`default_nettype wire

// ### verification/drive_command_word_decoder_props.sv
// Checker for the command word decoder
`timescale 1ns/100ps
`default_nettype none
module drive_command_word_decoder_props (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        cmdWrite,
  input wire logic [31:0] cmdWord,
  input wire logic        refNegative,
  input wire logic        faultActive,
  input wire logic        locFromBus,
  input wire logic        runEnFromBus,
  input wire logic        accelSetFromBus,
  input wire logic        torqueSetFromBus,
  input wire logic [1:0]  paramStopMode,
  input wire logic [15:0] driveCmdWord,
  input wire logic        stopCmd,
  input wire logic        startCmd,
  input wire logic [1:0]  stopMode,
  input wire logic        dirReverse,
  input wire logic        faultResetPulse,
  input wire logic        secondExternalLocation,
  input wire logic        runEnable,
  input wire logic        accelSetSelect,
  input wire logic        rampOutZero,
  input wire logic        rampHold,
  input wire logic        rampInZero,
  input wire logic        localLock,
  input wire logic        torqueBoundSetSelect,
  input wire logic        busControlTakeover,
  input wire logic        busReferenceTakeover,
  input wire logic [3:0]  userBits
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] w;
  always_ff @(posedge clock) w <= cmdWord;
  property p_copy; cmdWrite |=> driveCmdWord == (w[15:0] & 16'hFFF7); endproperty
  a_copy: assert property (p_copy) else $error("word copy wrong");
  property p_dir; !$past(sys_rst) |-> dirReverse == (driveCmdWord[2] ^ $past(refNegative)); endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_frst; !$past(sys_rst) |-> faultResetPulse == $past(cmdWrite & cmdWord[4] & ~driveCmdWord[4] & faultActive);
  endproperty
  a_frst: assert property (p_frst) else $error("fault reset wrong");
  property p_stop; cmdWrite |=> stopMode == (w[7] ? 2'h1 : w[8] ? 2'h2 : w[9] ? 2'h3 : $past(paramStopMode)); endproperty
  a_stop: assert property (p_stop) else $error("stop mode wrong");
  property p_run; cmdWrite && runEnFromBus |=> runEnable == !w[6]; endproperty
  a_run: assert property (p_run) else $error("run enable wrong");
  property p_loc; cmdWrite && locFromBus |=> secondExternalLocation == w[5]; endproperty
  a_loc: assert property (p_loc) else $error("location wrong");
  property p_keep; !locFromBus |=> $stable(secondExternalLocation); endproperty
  a_keep: assert property (p_keep) else $error("location moved");
  property p_user; cmdWrite |=> userBits == w[25:22]; endproperty
  a_user: assert property (p_user) else $error("user bits wrong");
  property p_flags;
    cmdWrite |=> {busReferenceTakeover, busControlTakeover, localLock, rampInZero, rampHold, rampOutZero,
                  startCmd, stopCmd} == {w[17:16], w[14:11], w[1:0]};
  endproperty
  a_flags: assert property (p_flags) else $error("command flags wrong");
  property p_accel; cmdWrite && accelSetFromBus |=> accelSetSelect == w[10]; endproperty
  a_accel: assert property (p_accel) else $error("ramp set wrong");
  property p_torque; cmdWrite && torqueSetFromBus |=> torqueBoundSetSelect == w[15]; endproperty
  a_torque: assert property (p_torque) else $error("torque set wrong");
  property p_runkeep; !runEnFromBus |=> $stable(runEnable); endproperty
  a_runkeep: assert property (p_runkeep) else $error("run enable moved");
  property p_once; faultResetPulse |=> !faultResetPulse; endproperty
  a_once: assert property (p_once) else $error("fault reset repeated");
  property p_rsvd; driveCmdWord[3] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit passed");
  c_frst: cover property (faultResetPulse);
  c_b2b: cover property (cmdWrite [*2]);
  c_keep: cover property (cmdWrite && !locFromBus);
endmodule // drive_command_word_decoder_props
bind drive_command_word_decoder drive_command_word_decoder_props u_drive_command_word_decoder_props (
  .clock(clock), .sys_rst(sys_rst), .cmdWrite(cmdWrite), .cmdWord(cmdWord), .refNegative(refNegative),
  .faultActive(faultActive), .locFromBus(locFromBus), .runEnFromBus(runEnFromBus),
  .accelSetFromBus(accelSetFromBus), .torqueSetFromBus(torqueSetFromBus), .paramStopMode(paramStopMode),
  .driveCmdWord(driveCmdWord), .stopCmd(stopCmd), .startCmd(startCmd), .stopMode(stopMode),
  .dirReverse(dirReverse), .faultResetPulse(faultResetPulse), .secondExternalLocation(secondExternalLocation),
  .runEnable(runEnable), .accelSetSelect(accelSetSelect), .rampOutZero(rampOutZero), .rampHold(rampHold),
  .rampInZero(rampInZero), .localLock(localLock), .torqueBoundSetSelect(torqueBoundSetSelect),
  .busControlTakeover(busControlTakeover), .busReferenceTakeover(busReferenceTakeover), .userBits(userBits));
`default_nettype wire

// ### verification/fb_master_model.sv
// Bus master model that writes the command word
`timescale 1ns/100ps
`default_nettype none
module fb_master_model (
  output logic        cmdWrite = 1'b0,
  output logic [31:0] cmdWord = 32'h0
);
  // Idle cycles show the inverted word so stale data cannot pass for fresh
  task automatic put(input logic wr, input logic [31:0] d);
    cmdWrite <= wr;
    cmdWord  <= wr ? d : ~cmdWord;
  endtask
endmodule // fb_master_model
`default_nettype wire

// ### verification/tb_drive_command_word_decoder.sv
// Self-checking bench for the command word decoder
`timescale 1ns/100ps
`default_nettype none
module tb_drive_command_word_decoder;
  logic        clock = 1'b0, sys_rst = 1'b1, refNegative = 1'b0, faultActive = 1'b0, cmdWrite, fr, dirReverse;
  logic        faultResetPulse;
  logic [3:0]  cfg = 4'h0, sel = 4'h0, userBits;
  logic [1:0]  pm = 2'h0, sm = 2'h0, stopMode;
  logic [31:0] cmdWord, seed = 32'hF36162BA, s = 32'h0;
  logic [15:0] driveCmdWord;
  wire logic [7:0] fl;
  wire logic [3:0] so;
  int          num_errors = 0, n_checks = 0;
  always #2.5 clock = ~clock;
  drive_command_word_decoder u_drive_command_word_decoder (.clock(clock), .sys_rst(sys_rst), .cmdWrite(cmdWrite),
    .cmdWord(cmdWord), .refNegative(refNegative), .faultActive(faultActive), .locFromBus(cfg[0]),
    .runEnFromBus(cfg[1]), .accelSetFromBus(cfg[2]), .torqueSetFromBus(cfg[3]), .paramStopMode(pm),
    .driveCmdWord(driveCmdWord), .stopCmd(fl[0]), .startCmd(fl[1]), .stopMode(stopMode), .dirReverse(dirReverse),
    .faultResetPulse(faultResetPulse), .secondExternalLocation(so[0]), .runEnable(so[1]), .accelSetSelect(so[2]),
    .rampOutZero(fl[2]), .rampHold(fl[3]), .rampInZero(fl[4]), .localLock(fl[5]), .torqueBoundSetSelect(so[3]),
    .busControlTakeover(fl[6]), .busReferenceTakeover(fl[7]), .userBits(userBits));
  fb_master_model u_fb_master_model (.cmdWrite(cmdWrite), .cmdWord(cmdWord));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin : watchdog
    #50000;
    num_errors++;
    end_sim();
  end
  initial begin : main
    logic [31:0] r;
    logic        d;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (400) begin
      @(posedge clock);
      fr = 1'b0;
      // Model reads what the design samples at this edge, before this edge's updates land
      if (cmdWrite) begin
        fr = cmdWord[4] & ~s[4] & faultActive;
        s = cmdWord & cmd_word_pkg::CMD_USED_MASK;
      end
      // Selections and stop method follow the held word at every edge, not only on writes
      for (int k = 0; k < 4; k++) if (cfg[k]) sel[k] = (k == 1) ? ~s[6] : s[(k == 0) ? 5 : (k == 2) ? 10 : 15];
      sm = s[7] ? 2'h1 : s[8] ? 2'h2 : s[9] ? 2'h3 : pm;
      d = s[2] ^ refNegative;
      r = xs();
      u_fb_master_model.put(r[0] | r[1], xs());
      refNegative <= r[2];
      faultActive <= r[3];
      cfg <= r[7:4];
      pm <= r[9:8];
      #1;
      chk("driveCmdWord", s[15:0], driveCmdWord);
      chk("flags", {s[17:16], s[14:11], s[1:0]}, fl);
      chk("stopMode", sm, stopMode);
      chk("dirReverse", d, dirReverse);
      chk("faultResetPulse", fr, faultResetPulse);
      chk("selects", sel, so);
      chk("userBits", s[25:22], userBits);
    end
    end_sim();
  end
endmodule // tb_drive_command_word_decoder
`default_nettype wire
